/* File: light_int_pkg.sv */
// Constants, register map and carrier types for the light threshold flags.
`default_nettype none
package light_int_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [7:0] CFG_OFFSET    = 8'h00;
    localparam logic [7:0] HIGH_OFFSET   = 8'h04;
    localparam logic [7:0] LOW_OFFSET    = 8'h08;
    localparam logic [7:0] RESULT_OFFSET = 8'h0C;

    // Register and result geometry.
    localparam int unsigned REG_W    = 16;
    localparam int unsigned EXP_W    = 4;
    localparam int unsigned MANT_W   = 12;
    localparam int unsigned EXP_LSB  = 12;
    localparam int unsigned LEVEL_W  = 27;
    localparam int unsigned FAULT_W  = 2;
    localparam int unsigned EOC_MSB  = 15;
    localparam int unsigned EOC_LSB  = 14;

    // Field codes.
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] EOC_MARK      = 2'h3;

    // Reset values.
    localparam logic [15:0] HIGH_RESET     = 16'hFFFF;
    localparam logic [15:0] LOW_RESET      = 16'h0000;
    localparam logic [15:0] RESULT_RESET   = 16'h0000;
    localparam logic [1:0]  MODE_RESET     = 2'h0;
    localparam logic        LATCH_RESET    = 1'h1;
    localparam logic        POLARITY_RESET = 1'h0;
    localparam logic [1:0]  FAULT_RESET    = 2'h0;

    // Layout of the configuration register, bit 15 first.
    typedef struct packed {
        logic [4:0] reserved_hi;
        logic [1:0] conv_mode;
        logic       reserved_mid;
        logic       conv_ready;
        logic       flag_high;
        logic       flag_low;
        logic       latch_select;
        logic       output_polarity;
        logic       reserved_lo;
        logic [1:0] fault_repeat_count;
    } cfg_t;

    // One finished conversion from the measurement path.
    typedef struct packed {
        logic        done;
        logic [15:0] result;
    } conv_t;

endpackage
`default_nettype wire

/* File: fault_repeat_counter.sv */
// Consecutive fault counter that qualifies high and low threshold events.
`timescale 1ns/1ns
`default_nettype none
module fault_repeat_counter #(
    parameter int unsigned FAULT_W = 2
) (
    // Clock and reset.
    input  wire logic               ref_clk_i,
    input  wire logic               resetn_i,
    // One comparison outcome per finished conversion.
    input  wire logic               sample_i,
    input  wire logic               above_i,
    input  wire logic               below_i,
    input  wire logic [FAULT_W-1:0] repeat_sel_i,
    // Qualified events, valid in the cycle of sample_i.
    output logic                    hit_high_o,
    output logic                    hit_low_o
);

    // The count needs one bit more than the selector to hold its top value.
    localparam int unsigned CNT_W = FAULT_W + 1;

    // Refuse selector widths whose run length the count cannot hold.
    if (FAULT_W < 1 || FAULT_W > 4) begin : g_bad_fault_w
        $error("fault_repeat_counter: FAULT_W must lie in 1..4.");
    end

    logic             run_high;
    logic             run_low;
    logic [CNT_W-1:0] run_count;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] need;

    // A selector value of n asks for n plus one equal outcomes in a row.
    assign need = {1'b0, repeat_sel_i} + CNT_W'(1);

    // Extend the run when the direction repeats, restart it at one on a new direction, clear it with no fault.
    always_comb begin
        next_count = run_count;
        if (above_i) begin
            next_count = run_high ? run_count : {CNT_W{1'b0}};
        end else if (below_i) begin
            next_count = run_low ? run_count : {CNT_W{1'b0}};
        end else begin
            next_count = {CNT_W{1'b0}};
        end
        if ((above_i || below_i) && next_count != {CNT_W{1'b1}}) begin
            next_count = next_count + CNT_W'(1);
        end
    end

    // Direction and length of the current run; a result inside the limits
    // clears both so the next fault starts a new run.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_high  <= 1'b0;
            run_low   <= 1'b0;
            run_count <= {CNT_W{1'b0}};
        end else if (sample_i) begin
            run_high  <= above_i;
            run_low   <= below_i && !above_i;
            run_count <= next_count;
        end
    end

    // Once the run is long enough every further repeat re-arms the event,
    // so a latched flag cleared by software comes back if the fault stays.
    assign hit_high_o = sample_i && above_i && (next_count >= need);
    assign hit_low_o  = sample_i && below_i && !above_i
                        && (next_count >= need);

endmodule
`default_nettype wire

/* File: light_threshold_interrupt_flags.sv */
// Threshold flags, conversion ready and open-drain alert with APB registers.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Latched mode, enough high faults: flag high, alert and ready set.
// - Latched mode, enough low faults: flag low, alert and ready set.
// - Conversion without enough faults sets ready only, flags and alert kept.
// - Latched mode, config read clears both flags, alert and ready.
// - Config write selecting shutdown leaves flags, alert and ready alone.
// - Config write selecting a running mode clears ready, and the alert too in transparent end-of-conversion mode.
// - Latched mode, alert response releases the alert, flags and ready kept.
// - Transparent mode, high faults: alert active, flag high set, low clear.
// - Transparent mode, low faults: alert inactive, flag low set, high clear.
// - Transparent: config accesses keep alert and flags; a read clears ready.
// - With latch select 0 the alert response is ignored entirely.
// - Pin low when active with polarity 0 or inactive with polarity 1.
// - A config read clears ready at once, so a second read shows zero.
// - Transparent alert behaviour holds only while low limit MSBs are not 11.
// - Events count only after the chosen number of equal outcomes in a row.
// - Config bit 4 picks latched (1) or transparent (0) comparison.
// - Two-bit fault repeat field sets the needed run of equal outcomes.
// - Alert is open drain; polarity 1 releases the pin when active.
// - Low limit MSBs at 11 select end-of-conversion behaviour.
module light_threshold_interrupt_flags #(
    parameter int unsigned APB_ADDR_W = 8
) (
    // Clock and reset.
    input  wire logic                  ref_clk_i,
    input  wire logic                  resetn_i,
    // APB slave.
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [APB_ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    // Finished conversions from the measurement path.
    input  wire light_int_pkg::conv_t  conv_i,
    // Pulse when an SMBus alert response addressed to us has completed.
    input  wire logic                  alert_resp_i,
    // Open-drain alert pin.
    output logic                       int_o,
    output logic                       int_oe_o
);

    // Refuse address widths the decoder cannot serve; the register offsets
    // need at least eight bits.
    if (APB_ADDR_W < 8 || APB_ADDR_W > 32) begin : g_bad_addr_w
        $error("light_threshold_interrupt_flags: APB_ADDR_W 8..32.");
    end

    // Stored configuration fields.
    logic [1:0]                        conv_mode;
    logic                              latch_select;
    logic                              output_polarity;
    logic [light_int_pkg::FAULT_W-1:0] fault_repeat_count;
    logic [15:0]                       high_limit;
    logic [15:0]                       low_limit;
    logic [15:0]                       result;

    // Reporting state.
    logic                              flag_high;
    logic                              flag_low;
    logic                              conv_ready;
    logic                              alert_active;

    // Bus decode.
    logic                              access_done;
    logic                              hit_cfg;
    logic                              hit_high_reg;
    logic                              hit_low_reg;
    logic                              hit_result;
    logic                              mapped;
    logic                              bad_access;
    logic                              cfg_read;
    logic                              cfg_write;
    logic                              run_write;
    light_int_pkg::cfg_t               wr_cfg;
    light_int_pkg::cfg_t               rd_cfg;
    logic [15:0]                       next_rdata;

    // Comparison path.
    logic [light_int_pkg::LEVEL_W-1:0] conv_level;
    logic [light_int_pkg::LEVEL_W-1:0] high_level;
    logic [light_int_pkg::LEVEL_W-1:0] low_level;
    logic [1:0]                        low_limit_exponent_msbs;
    logic                              eoc_mode;
    logic                              above;
    logic                              below;
    logic                              hit_high;
    logic                              hit_low;
    logic                              conv_done;

    // Results and limits share an exponent and mantissa format, so they are
    // expanded to one linear scale before comparing.
    function automatic logic [light_int_pkg::LEVEL_W-1:0] expand(
        input logic [15:0] code
    );
        logic [light_int_pkg::LEVEL_W-1:0] mant;
        logic [light_int_pkg::EXP_W-1:0]   expo;
        mant = {{(light_int_pkg::LEVEL_W - light_int_pkg::MANT_W){1'b0}},
                code[light_int_pkg::MANT_W-1:0]};
        expo = code[light_int_pkg::EXP_LSB +: light_int_pkg::EXP_W];
        return mant << expo;
    endfunction

    // An access ends at the edge where psel, penable and pready are all high.
    assign access_done = psel_i && penable_i && pready_o;
    assign hit_cfg      = (paddr_i == APB_ADDR_W'(light_int_pkg::CFG_OFFSET));
    assign hit_high_reg = (paddr_i == APB_ADDR_W'(light_int_pkg::HIGH_OFFSET));
    assign hit_low_reg  = (paddr_i == APB_ADDR_W'(light_int_pkg::LOW_OFFSET));
    assign hit_result   = (paddr_i ==
                           APB_ADDR_W'(light_int_pkg::RESULT_OFFSET));
    assign mapped       = hit_cfg || hit_high_reg || hit_low_reg || hit_result;
    // Writes to the read-only result register are refused like unmapped
    // addresses: an error answer and no side effect.
    assign bad_access   = !mapped || (pwrite_i && hit_result);

    // Side-effecting configuration accesses, seen at completion only.
    assign cfg_read  = access_done && !pwrite_i && hit_cfg;
    assign cfg_write = access_done && pwrite_i && hit_cfg;
    assign wr_cfg    = light_int_pkg::cfg_t'(pwdata_i[15:0]);
    // Only a running-mode write clears ready; a shutdown write must leave
    // ready, flags and alert untouched.
    assign run_write = cfg_write
                       && (wr_cfg.conv_mode
                           != light_int_pkg::MODE_SHUTDOWN);

    // Threshold comparison of each finished conversion.
    assign conv_done  = conv_i.done;
    assign conv_level = expand(conv_i.result);
    assign high_level = expand(high_limit);
    assign low_level  = expand(low_limit);
    // With inverted limits both may be true; high then takes priority.
    assign above = conv_level > high_level;
    assign below = conv_level < low_level;
    assign low_limit_exponent_msbs =
        low_limit[light_int_pkg::EOC_MSB:light_int_pkg::EOC_LSB];
    assign eoc_mode =
        (low_limit_exponent_msbs == light_int_pkg::EOC_MARK);

    // Qualifies each comparison by the length of its run.
    fault_repeat_counter #(
        .FAULT_W      (light_int_pkg::FAULT_W)
    ) u_fault_repeat_counter (
        .ref_clk_i    (ref_clk_i),
        .resetn_i     (resetn_i),
        .sample_i     (conv_done),
        .above_i      (above),
        .below_i      (below),
        .repeat_sel_i (fault_repeat_count),
        .hit_high_o   (hit_high),
        .hit_low_o    (hit_low)
    );

    // Configuration fields; status bits in the written word are ignored.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            conv_mode          <= light_int_pkg::MODE_RESET;
            latch_select       <= light_int_pkg::LATCH_RESET;
            output_polarity    <= light_int_pkg::POLARITY_RESET;
            fault_repeat_count <= light_int_pkg::FAULT_RESET;
        end else if (cfg_write) begin
            conv_mode          <= wr_cfg.conv_mode;
            latch_select       <= wr_cfg.latch_select;
            output_polarity    <= wr_cfg.output_polarity;
            fault_repeat_count <= wr_cfg.fault_repeat_count;
        end
    end

    // Limit registers; only the low 16 bits of the bus word are kept.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            high_limit <= light_int_pkg::HIGH_RESET;
            low_limit  <= light_int_pkg::LOW_RESET;
        end else if (access_done && pwrite_i) begin
            if (hit_high_reg) begin
                high_limit <= pwdata_i[15:0];
            end
            if (hit_low_reg) begin
                low_limit <= pwdata_i[15:0];
            end
        end
    end

    // The last result is kept for software; it is read only.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            result <= light_int_pkg::RESULT_RESET;
        end else if (conv_done) begin
            result <= conv_i.result;
        end
    end

    // Flag high. In latched mode a fresh event wins over a clearing read in
    // the same cycle so that no threshold crossing is lost.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flag_high <= 1'b0;
        end else if (latch_select) begin
            if (hit_high) begin
                flag_high <= 1'b1;
            end else if (cfg_read) begin
                flag_high <= 1'b0;
            end
        end else begin
            // Transparent: only comparison outcomes move the flag.
            if (hit_high) begin
                flag_high <= 1'b1;
            end else if (hit_low) begin
                flag_high <= 1'b0;
            end
        end
    end

    // Flag low, the mirror of flag high.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flag_low <= 1'b0;
        end else if (latch_select) begin
            if (hit_low) begin
                flag_low <= 1'b1;
            end else if (cfg_read) begin
                flag_low <= 1'b0;
            end
        end else begin
            if (hit_low) begin
                flag_low <= 1'b1;
            end else if (hit_high) begin
                flag_low <= 1'b0;
            end
        end
    end

    // Conversion ready marks every finished conversion; a configuration
    // read or a running-mode write clears it, but a shutdown write does not.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            conv_ready <= 1'b0;
        end else if (conv_done) begin
            conv_ready <= 1'b1;
        end else if (cfg_read) begin
            conv_ready <= 1'b0;
        end else if (run_write) begin
            conv_ready <= 1'b0;
        end
    end

    // Logical alert state before polarity. End-of-conversion mode fires on
    // every conversion; a shutdown write never touches the alert.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            alert_active <= 1'b0;
        end else if (latch_select) begin
            if (eoc_mode ? conv_done : (hit_high || hit_low)) begin
                alert_active <= 1'b1;
            end else if (cfg_read) begin
                alert_active <= 1'b0;
            end else if (alert_resp_i) begin
                alert_active <= 1'b0;
            end
        end else if (eoc_mode) begin
            // The alert response input is never looked at here.
            if (conv_done) begin
                alert_active <= 1'b1;
            end else if (cfg_read || run_write) begin
                alert_active <= 1'b0;
            end
        end else begin
            // Transparent hysteresis: config accesses and alert response
            // leave the alert following the comparison alone.
            if (hit_high) begin
                alert_active <= 1'b1;
            end else if (hit_low) begin
                alert_active <= 1'b0;
            end
        end
    end

    // Pin driver. The pull-down enable trails the alert state by one cycle
    // because it is registered from it; this keeps the pin glitch free.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            int_o    <= 1'b0;
            int_oe_o <= 1'b0;
        end else begin
            int_o    <= 1'b0;
            int_oe_o <= alert_active ^ output_polarity;
        end
    end

    // Read view of the configuration register with live status bits.
    always_comb begin
        rd_cfg                    = '0;
        rd_cfg.conv_mode          = conv_mode;
        rd_cfg.conv_ready         = conv_ready;
        rd_cfg.flag_high          = flag_high;
        rd_cfg.flag_low           = flag_low;
        rd_cfg.latch_select       = latch_select;
        rd_cfg.output_polarity    = output_polarity;
        rd_cfg.fault_repeat_count = fault_repeat_count;
    end

    // Read data multiplexer; unmapped addresses read as zero.
    always_comb begin
        next_rdata = 16'h0000;
        if (hit_cfg) begin
            next_rdata = rd_cfg;
        end else if (hit_high_reg) begin
            next_rdata = high_limit;
        end else if (hit_low_reg) begin
            next_rdata = low_limit;
        end else if (hit_result) begin
            next_rdata = result;
        end
    end

    // APB answer with one wait state: data, ready and error are registered
    // in the first access cycle so every bus output comes from a flip-flop.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else if (psel_i && penable_i && !pready_o) begin
            pready_o  <= 1'b1;
            pslverr_o <= bad_access;
            prdata_o  <= pwrite_i ? 32'h0000_0000 : {16'h0000, next_rdata};
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

/* File: light_flags_chk.sv */
// Port-level assertions for the light threshold flag block.
`timescale 1ns/1ns
`default_nettype none
module light_flags_chk #(
    parameter int unsigned APB_ADDR_W = 8
) (
    // Clock, reset and bus.
    input wire logic                  ref_clk_i,
    input wire logic                  resetn_i,
    input wire logic                  psel_i,
    input wire logic                  penable_i,
    input wire logic                  pwrite_i,
    input wire logic [APB_ADDR_W-1:0] paddr_i,
    input wire logic [31:0]           prdata_o,
    input wire logic                  pready_o,
    input wire logic                  pslverr_o,
    // Events and alert pin.
    input wire light_int_pkg::conv_t  conv_i,
    input wire logic                  alert_resp_i,
    input wire logic                  int_o,
    input wire logic                  int_oe_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // First access cycle, before the single wait state ends.
    wire logic first_acc = psel_i && penable_i && !pready_o;
    // A cycle with no cause that may move the alert pin.
    sequence quiet_s;
        !psel_i && !conv_i.done && !alert_resp_i;
    endsequence
    AST_READY_WAIT: assert property (first_acc |=> pready_o)
        else $error("ready missing after access");
    AST_READY_PULSE: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    AST_READY_CAUSE: assert property (pready_o |-> $past(first_acc))
        else $error("ready without access");
    AST_ERR_QUAL: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    AST_RDATA_IDLE: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside answer");
    AST_UNMAPPED: assert property (first_acc &&
        paddr_i > light_int_pkg::RESULT_OFFSET |=> pslverr_o)
        else $error("unmapped access accepted");
    AST_RO_RESULT: assert property (first_acc && pwrite_i &&
        paddr_i == light_int_pkg::RESULT_OFFSET |=> pslverr_o)
        else $error("result write accepted");
    AST_PIN_VALUE: assert property (int_o == 1'b0)
        else $error("open drain pin driven high");
    AST_OE_HOLD: assert property (quiet_s [*3] |=> $stable(int_oe_o))
        else $error("pin moved without cause");
endmodule
bind light_threshold_interrupt_flags light_flags_chk #(
    .APB_ADDR_W(APB_ADDR_W)
) i_chk (.ref_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .prdata_o, .pready_o, .pslverr_o, .conv_i, .alert_resp_i, .int_o,
    .int_oe_o);
`default_nettype wire

/* File: smbus_host_model.sv */
// Behavioural host: alert line pull-up and alert response pulses.
`timescale 1ns/1ns
`default_nettype none
module smbus_host_model (
    // Clock, reset and bench request.
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    input  wire logic ara_req_i,
    // Alert line.
    input  wire logic pin_oe_i,
    input  wire logic pin_val_i,
    output logic      pin_level_o,
    output logic      alert_resp_o
);
    // The line has a pull-up, so a released pin reads high.
    assign pin_level_o = pin_oe_i ? pin_val_i : 1'b1;
    // The response completes one cycle after the bench asks for it.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            alert_resp_o <= 1'b0;
        end else begin
            alert_resp_o <= ara_req_i;
        end
    end
endmodule
`default_nettype wire

/* File: light_threshold_interrupt_flags_tb.sv */
// Self-checking bench for the light threshold flag block.
`timescale 1ns/1ns
`default_nettype none
module light_threshold_interrupt_flags_tb;
    logic                 ref_clk_i = 1'b0;
    logic                 resetn_i = 1'b0;
    logic                 psel_i = 1'b0;
    logic                 penable_i = 1'b0;
    logic                 pwrite_i = 1'b0;
    logic                 ara_req = 1'b0;
    logic [7:0]           paddr_i = 8'h00;
    logic [31:0]          pwdata_i = 32'h0;
    logic [31:0]          prdata_o;
    logic                 pready_o, pslverr_o, int_o, int_oe_o, resp, pin;
    light_int_pkg::conv_t conv_i = '0;
    logic [33:0]          notes[$];
    logic [33:0]          nt;
    int                   num_errors = 0;
    int                   checked = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    light_threshold_interrupt_flags #(.APB_ADDR_W(8))
    i_light_threshold_interrupt_flags (.ref_clk_i, .resetn_i, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
        .pslverr_o, .conv_i, .alert_resp_i(resp), .int_o, .int_oe_o);
    smbus_host_model i_smbus_host_model (.ref_clk_i, .resetn_i,
        .ara_req_i(ara_req), .pin_oe_i(int_oe_o), .pin_val_i(int_o),
        .pin_level_o(pin), .alert_resp_o(resp));
    task automatic wrap_up();
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
        checked++;
        if (e !== s) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Expected value is noted first; the monitor below compares it.
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic e,
                       logic [31:0] x);
        int n;
        notes.push_back({!w, e, x});
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            wrap_up();
        end
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] x);
        apb(1'b0, a, 32'h0, 1'b0, x);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d, 1'b0, 32'h0);
    endtask
    task automatic conv(logic [15:0] r);
        @(posedge ref_clk_i);
        conv_i <= {1'b1, r};
        @(posedge ref_clk_i);
        conv_i <= '0;
    endtask
    task automatic ara();
        @(posedge ref_clk_i);
        ara_req <= 1'b1;
        @(posedge ref_clk_i);
        ara_req <= 1'b0;
    endtask
    // The pin lags the alert state by one cycle, so two edges suffice.
    task automatic pchk(logic e);
        repeat (2) @(posedge ref_clk_i);
        #1;
        cmp("pin", {31'h0, e}, {31'h0, pin});
    endtask
    // Config word: mode, {ready, flag high, flag low}, latch, pol, count.
    function automatic logic [31:0] cv(logic [1:0] m, logic [2:0] f,
                                       logic l, logic p, logic [1:0] c);
        return {21'h0, m, 1'b0, f, l, p, 1'b0, c};
    endfunction
    // Random results with exponent 0 against limits 0x0100 and 0x0080.
    function automatic logic [15:0] hi_r();
        return 16'h0101 + 16'($urandom % 32'h0EFF);
    endfunction
    function automatic logic [15:0] lo_r();
        return 16'($urandom % 32'h0080);
    endfunction
    function automatic logic [15:0] mid_r();
        return 16'h0080 + 16'($urandom % 32'h0081);
    endfunction
    // Every answer is matched to the oldest note.
    always @(posedge ref_clk_i) begin
        if (pready_o === 1'b1) begin
            nt = notes.pop_front();
            cmp("pslverr", {31'h0, nt[32]}, {31'h0, pslverr_o});
            if (nt[33]) begin
                cmp("prdata", nt[31:0], prdata_o);
            end
        end
    end
    initial begin
        void'($urandom(32'hDC0F));
        repeat (20) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        rd(8'h00, cv(2'h0, 3'h0, 1'b1, 1'b0, 2'h0));
        rd(8'h04, 32'h0000FFFF);
        apb(1'b0, 8'h10, 32'h0, 1'b1, 32'h0);
        apb(1'b1, 8'h0C, 32'h5, 1'b1, 32'h0);
        wr(8'h04, 32'h0100);
        wr(8'h08, 32'h0080);
        wr(8'h00, cv(2'h1, 3'h0, 1'b1, 1'b0, 2'h1));
        conv(hi_r());
        conv(mid_r());
        conv(hi_r());
        pchk(1'b1);
        rd(8'h00, cv(2'h1, 3'h4, 1'b1, 1'b0, 2'h1));
        conv(hi_r());
        pchk(1'b0);
        ara();
        pchk(1'b1);
        rd(8'h00, cv(2'h1, 3'h6, 1'b1, 1'b0, 2'h1));
        rd(8'h00, cv(2'h1, 3'h0, 1'b1, 1'b0, 2'h1));
        conv(lo_r());
        conv(lo_r());
        pchk(1'b0);
        wr(8'h00, cv(2'h0, 3'h0, 1'b1, 1'b0, 2'h1));
        pchk(1'b0);
        rd(8'h00, cv(2'h0, 3'h5, 1'b1, 1'b0, 2'h1));
        pchk(1'b1);
        conv(lo_r());
        pchk(1'b0);
        wr(8'h00, cv(2'h1, 3'h0, 1'b1, 1'b0, 2'h1));
        rd(8'h00, cv(2'h1, 3'h1, 1'b1, 1'b0, 2'h1));
        pchk(1'b1);
        for (int n = 0; n < 4; n++) begin
            wr(8'h00, cv(2'h1, 3'h0, 1'b0, 1'b0, 2'(n)));
            repeat (n) conv(hi_r());
            pchk(1'b1);
            conv(hi_r());
            pchk(1'b0);
            repeat (n + 1) conv(lo_r());
            pchk(1'b1);
        end
        wr(8'h00, cv(2'h1, 3'h0, 1'b0, 1'b1, 2'h0));
        pchk(1'b0);
        conv(hi_r());
        pchk(1'b1);
        ara();
        pchk(1'b1);
        rd(8'h00, cv(2'h1, 3'h6, 1'b0, 1'b1, 2'h0));
        rd(8'h00, cv(2'h1, 3'h2, 1'b0, 1'b1, 2'h0));
        pchk(1'b1);
        conv(lo_r());
        pchk(1'b0);
        wr(8'h04, 32'hFFFF);
        wr(8'h08, 32'hC080);
        conv(mid_r());
        pchk(1'b1);
        wr(8'h00, cv(2'h1, 3'h0, 1'b1, 1'b0, 2'h0));
        rd(8'h00, cv(2'h1, 3'h1, 1'b1, 1'b0, 2'h0));
        conv(16'hD100);
        pchk(1'b0);
        ara();
        pchk(1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
